// ===== core/adc_ctl_pkg.sv
// constants, register map and types for the converter control block
package adc_ctl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PHASE  = 8'h07;
  localparam logic [7:0] IDX_STATUS = 8'h09;
  localparam logic [7:0] IDX_CFG1   = 8'h0a;
  localparam logic [7:0] IDX_CFG2   = 8'h0b;
  // values after reset
  localparam logic [7:0] PHASE_RST  = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'ha3;
  localparam logic [7:0] CFG1_RST   = 8'h10;
  localparam logic [7:0] CFG2_RST   = 8'h0c;
  // status_and_comm_control fields
  localparam int ST_LOOP_LSB = 6;
  localparam int ST_LTY_BIT  = 5;
  localparam int ST_HIZ_BIT  = 4;
  localparam int ST_MODE_LSB = 2;
  // converter_config_one fields
  localparam int C1_PRE_LSB  = 6;
  localparam int C1_OSR_LSB  = 4;
  localparam int C1_WID_LSB  = 2;
  // converter_config_two fields
  localparam int C2_RST_LSB  = 6;
  localparam int C2_SHD_LSB  = 4;
  localparam int C2_DITH_LSB = 2;
  localparam int C2_VREF_BIT = 1;
  // timing counts and the bus NONSEQ transfer code
  localparam logic [1:0] SETTLE_PERIODS = 2'd3;
  localparam logic [2:0] MOD_DIV        = 3'd4;
  localparam logic [1:0] HTRANS_NONSEQ  = 2'b10;
  // strobe routing codes
  typedef enum logic [1:0] {
    ROUTE_LAG  = 2'b00,
    ROUTE_CH0  = 2'b01,
    ROUTE_CH1  = 2'b10,
    ROUTE_BOTH = 2'b11
  } route_t;
  // strobe pin states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_PULSE = 2'b10
  } strobe_t;
endpackage

// ===== core/channel_ready_gen.sv
// per-channel output-rate tick with phase offset and settling holdoff
`timescale 1ns/10ps
module channel_ready_gen (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_enable,
  input  wire logic       i_dm_tick,
  input  wire logic [1:0] i_osr_code,
  input  wire logic [7:0] i_delay,
  input  wire logic       i_settle_sel,
  output logic            o_ready
);
  import adc_ctl_pkg::*;

  logic [7:0] count_q, count_d;
  logic [1:0] settle_q, settle_d;
  logic       ready_q, ready_d;
  logic [7:0] mask;
  logic       hit;

  // period mask: 32 << osr modulator ticks per output period
  assign mask = 8'hff >> (2'd3 - i_osr_code);
  assign hit  = i_enable & i_dm_tick &
                ((count_q & mask) == (i_delay & mask));

  // counters restart whenever the channel is held off
  always_comb begin
    count_d  = 8'h00;
    settle_d = 2'd0;
    ready_d  = 1'b0;
    if (i_enable) begin
      count_d  = i_dm_tick ? count_q + 8'h01 : count_q;
      settle_d = settle_q;
      // R16 settle holdoff
      if (hit && settle_q != SETTLE_PERIODS)
        settle_d = settle_q + 2'd1;
      ready_d = hit & (~i_settle_sel | (settle_q == SETTLE_PERIODS));
    end
  end

  // register stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_q  <= 8'h00;
      settle_q <= 2'd0;
      ready_q  <= 1'b0;
    end else begin
      count_q  <= count_d;
      settle_q <= settle_d;
      ready_q  <= ready_d;
    end
  end

  assign o_ready = ready_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  settle_hold_a: assert property ( // R16
    (settle_q != SETTLE_PERIODS && i_settle_sel) |=> !o_ready)
    else $error("ready pulse given before settling");
  off_quiet_a: assert property ( // R20
    !i_enable |=> !o_ready && count_q == 8'h00)
    else $error("disabled channel still running");
endmodule

// ===== core/dual_adc_ready_and_config.sv
// register file, ready strobe routing and data latching for two channels
`timescale 1ns/10ps
// Overview of operation
// R01 - idle-drive bit 1 drives strobe high when idle, 0 floats it
// R02 - routing 11 puts both channels' ready pulses on the strobe
// R03 - routing 10 passes only channel 1 pulses
// R04 - routing 01 passes only channel 0 pulses
// R05 - routing 00 passes only the lagging channel's pulses
// R06 - linked mode latches both channels together at the ready event
// R07 - linked mode gives no pulse if either channel is off
// R08 - a channel in reset or shutdown gives no pulses
// R09 - independent modes capture read data when the read starts
// R10 - linked mode also freezes latched output when a read begins
// R11 - reading the status register sets both ready flags
// R12 - a channel's ready event clears its flag; writes ignored
// R13 - linked mode clears both flags on the lagging channel event
// R14 - flag bit1 is channel 1, bit0 channel 0; 1 means not ready
// R15 - address loop field steers the read address counter
// R16 - latency bit withholds pulses for three output periods
// R17 - prescaler divides master clock by 1, 2, 4 or 8
// R18 - oversampling code selects 32, 64, 128 or 256
// R19 - width bits pick 16 or 24 bit words per channel
// R20 - reset and shutdown bits hold each channel off
// R21 - dither bits enable dithering per channel, both on at reset
// R22 - host writes config two bit0 to 1 and keeps reserved zeros
// R23 - positive phase makes channel 0 lag, negative makes it lead
// R24 - the ready strobe is an active low pulse
module dual_adc_ready_and_config (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic [23:0] i_ch0_data,
  input  wire logic [23:0] i_ch1_data,
  input  wire logic        i_read_start,
  input  wire logic        i_read_busy,
  output logic      [23:0] o_ch0_word,
  output logic      [23:0] o_ch1_word,
  output logic             o_conversion_ready_strobe,
  output logic             o_conversion_ready_strobe_oe_n,
  output logic      [1:0]  o_channel_ready_flags,
  output logic      [1:0]  o_addr_loop_mode,
  output logic             o_converter_internal_clock,
  output logic             o_modulator_sample_clock,
  output logic      [1:0]  o_chan_hold_reset,
  output logic      [1:0]  o_chan_shutdown,
  output logic      [1:0]  o_dither_enable,
  output logic             o_external_reference_select
);
  import adc_ctl_pkg::*;

  logic [7:0]  phase_q, phase_d;
  logic [7:0]  status_q, status_d;
  logic [7:0]  cfg1_q, cfg1_d;
  logic [7:0]  cfg2_q, cfg2_d;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_idx_q, wr_idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic        acc, addr_ok, rd_status;
  logic [7:0]  idx;
  logic [2:0]  pre_cnt_q, pre_cnt_d;
  logic [2:0]  dm_cnt_q, dm_cnt_d;
  logic        am_tick, dm_tick;
  logic [2:0]  pre_max;
  logic [1:0]  oversample_ratio;
  route_t      route;
  logic [1:0]  chan_en;
  logic [1:0]  rdy;
  logic [7:0]  phase_ext;
  logic        ch0_lags;
  logic        both_en, linked, ev_linked;
  logic [1:0]  flag_clr;
  logic        strobe_src;
  strobe_t     st_q, st_d;
  logic [23:0] link0_q, link0_d, link1_q, link1_d;
  logic [23:0] word0_q, word0_d, word1_q, word1_d;
  logic [7:0]  delay0, delay1;

  // zero-wait slave, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_q;

  // address phase decode; only aligned words in the low map answer
  assign acc     = i_hsel & (i_htrans == HTRANS_NONSEQ) & i_hready;
  assign idx     = i_haddr[9:2];
  assign addr_ok = (i_haddr[31:10] == 22'h0) & (i_haddr[1:0] == 2'b00);
  // R11 read sets flags
  assign rd_status = acc & ~i_hwrite & addr_ok & (idx == IDX_STATUS);

  // field views of the control registers
  assign route   = route_t'(status_q[ST_MODE_LSB +: 2]);
  assign oversample_ratio     = cfg1_q[C1_OSR_LSB +: 2];
  // R20 per-channel hold-off
  assign chan_en = ~cfg2_q[C2_RST_LSB +: 2] & ~cfg2_q[C2_SHD_LSB +: 2];
  assign both_en = &chan_en;
  assign linked  = (route == ROUTE_LAG);

  // R17 prescaler: divisor 1 << code, terminal count is divisor - 1
  assign pre_max = 3'((4'h1 << cfg1_q[C1_PRE_LSB +: 2]) - 4'h1);
  assign am_tick = (pre_cnt_q == pre_max);
  assign dm_tick = am_tick & (dm_cnt_q == MOD_DIV - 3'd1);

  // converter clock chain counters
  always_comb begin
    pre_cnt_d = am_tick ? 3'd0 : pre_cnt_q + 3'd1;
    dm_cnt_d  = dm_cnt_q;
    if (am_tick)
      dm_cnt_d = dm_tick ? 3'd0 : dm_cnt_q + 3'd1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_cnt_q <= 3'd0;
      dm_cnt_q  <= 3'd0;
    end else begin
      pre_cnt_q <= pre_cnt_d;
      dm_cnt_q  <= dm_cnt_d;
    end
  end

  assign o_converter_internal_clock = am_tick;
  assign o_modulator_sample_clock   = dm_tick;

  // R23 sign-extend phase from the OVERSAMPLE_RATIO-dependent sign bit
  assign phase_ext = 8'($signed(phase_q << oversample_ratio) >>> oversample_ratio);
  assign ch0_lags  = ~phase_ext[7] & (phase_ext != 8'h00);
  assign delay0    = ch0_lags ? phase_ext : 8'h00;
  assign delay1    = phase_ext[7] ? 8'(-phase_ext) : 8'h00;

  // R08 a disabled channel makes no ticks
  channel_ready_gen u_ch0 (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_enable     (chan_en[0]),
    .i_dm_tick    (dm_tick),
    .i_osr_code   (oversample_ratio),
    .i_delay      (delay0),
    .i_settle_sel (status_q[ST_LTY_BIT]),
    .o_ready      (rdy[0])
  );

  channel_ready_gen u_ch1 (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_enable     (chan_en[1]),
    .i_dm_tick    (dm_tick),
    .i_osr_code   (oversample_ratio),
    .i_delay      (delay1),
    .i_settle_sel (status_q[ST_LTY_BIT]),
    .o_ready      (rdy[1])
  );

  // R07 linked event needs both channels running, on the lagging one
  assign ev_linked = both_en & (ch0_lags ? rdy[0] : rdy[1]);
  // R13 linked clears both flags together
  assign flag_clr  = linked ? {2{ev_linked}} : rdy;

  // strobe routing
  always_comb begin
    case (route)
      // R04 channel 0 only
      ROUTE_CH0:  strobe_src = rdy[0];
      // R03 channel 1 only
      ROUTE_CH1:  strobe_src = rdy[1];
      // R02 both channels
      ROUTE_BOTH: strobe_src = |rdy;
      // R05 lagging channel
      ROUTE_LAG:  strobe_src = ev_linked;
      default:    strobe_src = 1'b0;
    endcase
  end

  // strobe pin state: one-cycle low pulse per routed event
  always_comb begin
    case (st_q)
      ST_IDLE:  st_d = strobe_src ? ST_PULSE : ST_IDLE;
      ST_PULSE: st_d = strobe_src ? ST_PULSE : ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  // R24 low pulse driven; R01 idle level driven high or released
  assign o_conversion_ready_strobe = (st_q != ST_PULSE);
  assign o_conversion_ready_strobe_oe_n =
    ~((st_q == ST_PULSE) | status_q[ST_HIZ_BIT]);

  // register file next state and bus read data
  always_comb begin
    phase_d   = phase_q;
    status_d  = status_q;
    cfg1_d    = cfg1_q;
    cfg2_d    = cfg2_q;
    wr_pend_d = acc & i_hwrite & addr_ok;
    wr_idx_d  = idx;
    rdata_d   = rdata_q;
    if (wr_pend_q) begin
      case (wr_idx_q)
        IDX_PHASE:  phase_d = i_hwdata[7:0];
        // R12 flag bits ignore writes; R15 loop, R16 latency fields
        IDX_STATUS: status_d[7:2] = i_hwdata[7:2];
        // R17 R18 R19 divider, ratio and width
        IDX_CFG1:   cfg1_d = i_hwdata[7:0];
        // R20 R21 holds, dither, reference
        IDX_CFG2:   cfg2_d = i_hwdata[7:0];
        default:    phase_d = phase_q;
      endcase
    end
    // R11 read sets both flags
    if (rd_status)
      status_d[1:0] = 2'b11;
    // R12 ready event clears, winning over a read in the same cycle
    if (flag_clr[0])
      status_d[0] = 1'b0;
    if (flag_clr[1])
      status_d[1] = 1'b0;
    if (acc && !i_hwrite) begin
      rdata_d = 32'h0;
      if (addr_ok) begin
        case (idx)
          IDX_PHASE:  rdata_d[7:0] = phase_q;
          IDX_STATUS: rdata_d[7:0] = status_q;
          IDX_CFG1:   rdata_d[7:0] = cfg1_q;
          IDX_CFG2:   rdata_d[7:0] = cfg2_q;
          default:    rdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_q   <= PHASE_RST;
      status_q  <= STATUS_RST;
      cfg1_q    <= CFG1_RST;
      cfg2_q    <= CFG2_RST;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      rdata_q   <= 32'h0;
    end else begin
      phase_q   <= phase_d;
      status_q  <= status_d;
      cfg1_q    <= cfg1_d;
      cfg2_q    <= cfg2_d;
      wr_pend_q <= wr_pend_d;
      wr_idx_q  <= wr_idx_d;
      rdata_q   <= rdata_d;
    end
  end

  // R14 flag bit order: bit1 channel 1, bit0 channel 0
  assign o_channel_ready_flags       = status_q[1:0];
  assign o_addr_loop_mode            = status_q[ST_LOOP_LSB +: 2];
  assign o_chan_hold_reset           = cfg2_q[C2_RST_LSB +: 2];
  assign o_chan_shutdown             = cfg2_q[C2_SHD_LSB +: 2];
  assign o_dither_enable             = cfg2_q[C2_DITH_LSB +: 2];
  assign o_external_reference_select = cfg2_q[C2_VREF_BIT];

  // R19 16-bit mode keeps the upper 16 bits right aligned
  function automatic logic [23:0] fmt(input logic [23:0] d,
                                      input logic w24);
    fmt = w24 ? d : {8'h00, d[23:8]};
  endfunction

  // data snapshots for the reader
  always_comb begin
    link0_d = link0_q;
    link1_d = link1_q;
    word0_d = word0_q;
    word1_d = word1_q;
    // R06 linked pair latched at the ready event, frozen during a read
    if (ev_linked && !i_read_busy) begin
      link0_d = i_ch0_data;
      link1_d = i_ch1_data;
    end
    // R09 R10 captured once at the start of a read
    if (i_read_start) begin
      word0_d = fmt(linked ? link0_q : i_ch0_data, cfg1_q[C1_WID_LSB]);
      word1_d = fmt(linked ? link1_q : i_ch1_data,
                    cfg1_q[C1_WID_LSB + 1]);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link0_q <= 24'h0;
      link1_q <= 24'h0;
      word0_q <= 24'h0;
      word1_q <= 24'h0;
    end else begin
      link0_q <= link0_d;
      link1_q <= link1_d;
      word0_q <= word0_d;
      word1_q <= word1_d;
    end
  end

  assign o_ch0_word = word0_q;
  assign o_ch1_word = word1_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  flag_set_a: assert property ( // R11
    rd_status && flag_clr == 2'b00 |=> o_channel_ready_flags == 2'b11)
    else $error("status read did not set flags");
  flag_clear_a: assert property ( // R12
    !linked && rdy[0] |=> o_channel_ready_flags[0] == 1'b0)
    else $error("channel 0 flag not cleared");
  linked_flags_a: assert property ( // R13
    linked && ev_linked |=> o_channel_ready_flags == 2'b00)
    else $error("linked event did not clear both flags");
  route_ch0_a: assert property ( // R04
    route == ROUTE_CH0 && rdy[1] && !rdy[0] |=> st_q == ST_IDLE)
    else $error("channel 1 pulse leaked in channel 0 routing");
  route_ch1_a: assert property ( // R03
    route == ROUTE_CH1 && rdy[0] && !rdy[1] |=> st_q == ST_IDLE)
    else $error("channel 0 pulse leaked in channel 1 routing");
  route_both_a: assert property ( // R02
    route == ROUTE_BOTH && |rdy |=> !o_conversion_ready_strobe)
    else $error("ready pulse missing in both routing");
  linked_off_a: assert property ( // R07
    linked && !both_en |=> st_q == ST_IDLE)
    else $error("linked strobe with a channel off");
  idle_level_a: assert property ( // R01
    st_q == ST_IDLE |->
      o_conversion_ready_strobe_oe_n == !status_q[ST_HIZ_BIT])
    else $error("idle strobe drive wrong");
  pulse_low_a: assert property ( // R24
    strobe_src |=> !o_conversion_ready_strobe &&
                   !o_conversion_ready_strobe_oe_n)
    else $error("strobe pulse not driven low");
  read_freeze_a: assert property ( // R10
    !i_read_start |=> $stable(o_ch0_word) && $stable(o_ch1_word))
    else $error("read data changed without a read start");

  linked_ev_c: cover property (linked && ev_linked);
  both_route_c: cover property (route == ROUTE_BOTH && rdy == 2'b11);
  status_rd_c: cover property (rd_status ##1 flag_clr != 2'b00);
endmodule

// ===== dv/serial_host_model.sv
// host-side partner: live channel data and serial read framing
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_go,
  output logic      [23:0] o_ch0_data,
  output logic      [23:0] o_ch1_data,
  output logic             o_read_start,
  output logic             o_read_busy,
  output logic      [23:0] o_seen0,
  output logic      [23:0] o_seen1
);
  logic [4:0] left_q;
  // data moves every cycle so a late or early capture shows up
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ch0_data   <= 24'h000000;
      o_ch1_data   <= 24'h800000;
      o_read_start <= 1'b0;
      o_read_busy  <= 1'b0;
      left_q       <= 5'h00;
      o_seen0      <= 24'h000000;
      o_seen1      <= 24'h000000;
    end else begin
      o_ch0_data   <= o_ch0_data + 24'h010203;
      o_ch1_data   <= o_ch1_data - 24'h030507;
      o_read_start <= i_go && !o_read_busy;
      // a frame lasts some 32 cycles; a new start waits for its end
      if (i_go && !o_read_busy) begin
        o_read_busy <= 1'b1;
        left_q      <= 5'h1f;
      end else if (left_q != 5'h00) begin
        left_q <= left_q - 5'h01;
      end else begin
        o_read_busy <= 1'b0;
      end
      // what the device sees at the start edge
      if (o_read_start) begin
        o_seen0 <= o_ch0_data;
        o_seen1 <= o_ch1_data;
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_top;
  import adc_ctl_pkg::*;
  logic        i_clk, i_arst_n, hsel, hwrite, go, cnt_en;
  logic        hreadyout, hresp, strobe, strobe_oe_n, iclk, mclk;
  logic        rs, rb, vref;
  logic [1:0]  htrans, flags, loop, hold, shd, dith;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [23:0] d0, d1, w0, w1, s0, s1;
  int          errors, num_checks, pulses, iticks, mticks, cyc;
  logic        rb_q;
  logic [23:0] lk0, lk1;

  dual_adc_ready_and_config dut_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hready(1'b1), .i_hwdata(hwdata), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_ch0_data(d0),
    .i_ch1_data(d1), .i_read_start(rs), .i_read_busy(rb),
    .o_ch0_word(w0), .o_ch1_word(w1), .o_conversion_ready_strobe(strobe),
    .o_conversion_ready_strobe_oe_n(strobe_oe_n),
    .o_channel_ready_flags(flags), .o_addr_loop_mode(loop),
    .o_converter_internal_clock(iclk), .o_modulator_sample_clock(mclk),
    .o_chan_hold_reset(hold), .o_chan_shutdown(shd),
    .o_dither_enable(dith), .o_external_reference_select(vref));

  serial_host_model host_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_go(go), .o_ch0_data(d0),
    .o_ch1_data(d1), .o_read_start(rs), .o_read_busy(rb),
    .o_seen0(s0), .o_seen1(s1));

  // clock at 40 MHz
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // pulse and tick counting, pin drive watch and run limit
  always @(posedge i_clk) begin
    cyc++;
    if (cnt_en && strobe === 1'b0) pulses <= pulses + 1;
    if (cnt_en && iclk === 1'b1) iticks <= iticks + 1;
    if (cnt_en && mclk === 1'b1) mticks <= mticks + 1;
    if (strobe === 1'b0) chk(strobe_oe_n, 1'b0);
    // linked pair as latched at the event before each strobe pulse
    rb_q <= rb;
    if (strobe === 1'b0 && rb_q === 1'b0) begin
      lk0 <= d0 - 24'h010203;
      lk1 <= d1 + 24'h030507;
    end
    if (cyc == 40000) begin
      errors++;
      end_of_test;
    end
  end

  // one single-word transfer; entered just after a rising edge
  task automatic ahb(input logic [7:0] idx, input logic wr,
                     input logic [7:0] wd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    @(posedge i_clk);
    while (hreadyout !== 1'b1) @(posedge i_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    @(posedge i_clk);
    while (hreadyout !== 1'b1) @(posedge i_clk);
    rd = hrdata;
  endtask

  // counts strobe pulses and clock ticks over n edges
  task automatic window(input int n);
    pulses = 0;
    iticks = 0;
    mticks = 0;
    cnt_en <= 1'b1;
    repeat (n) @(posedge i_clk);
    cnt_en <= 1'b0;
    @(posedge i_clk);
  endtask

  // waits for a routed strobe pulse; the first edge lets a new route settle
  task automatic wait_pulse;
    @(posedge i_clk);
    repeat (300) begin
      @(negedge i_clk);
      if (strobe === 1'b0) break;
    end
    chk(strobe, 1'b0);
    @(posedge i_clk);
  endtask

  // reset values, released pin and an unmapped hole
  task automatic t_reset;
    chk({loop, dith, hold, shd, vref}, 9'h160);
    chk({strobe, strobe_oe_n}, 2'b11);
    chk({hreadyout, hresp}, 2'b10);
    ahb(IDX_PHASE, 1'b0, 8'h00);
    chk(rd, 8'h00);
    ahb(IDX_STATUS, 1'b0, 8'h00);
    chk(rd, 8'ha3);
    ahb(IDX_CFG1, 1'b0, 8'h00);
    chk(rd, 8'h10);
    ahb(IDX_CFG2, 1'b0, 8'h00);
    chk(rd, 8'h0c);
    ahb(8'h20, 1'b1, 8'hff);
    ahb(8'h20, 1'b0, 8'h00);
    chk(rd, 32'h0);
  endtask

  // loop codes, divider ticks and channel control outputs
  task automatic t_fields;
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      ahb(IDX_STATUS, 1'b1, {c[1:0], 6'h30});
      ahb(IDX_STATUS, 1'b0, 8'h00);
      chk(loop, c[1:0]);
      chk(rd[7:2], {c[1:0], 4'hc});
      ahb(IDX_CFG1, 1'b1, {c[1:0], c[1:0], 4'h0});
      ahb(IDX_CFG1, 1'b0, 8'h00);
      chk(rd, {c[1:0], c[1:0], 4'h0});
      repeat (16) @(posedge i_clk);
      window(64);
      chk(iticks, 64 >> c);
      chk(mticks, 16 >> c);
    end
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h57 : 8'ha9;
      ahb(IDX_CFG2, 1'b1, v);
      ahb(IDX_CFG2, 1'b0, 8'h00);
      chk({hold, shd, dith, vref}, v[7:1]);
      chk(rd, v);
    end
  endtask

  // routing, linking, channel off and settling holdoff
  task automatic t_strobe;
    logic [7:0] rt [9] = '{8'h9c, 8'h98, 8'h94, 8'h90, 8'h90, 8'h9c,
                           8'h98, 8'hb4, 8'hb4};
    logic [7:0] c2 [9] = '{8'h0d, 8'h0d, 8'h0d, 8'h0d, 8'h4d, 8'h2d,
                           8'h8d, 8'h4d, 8'h0d};
    int         ex [9] = '{16, 8, 8, 8, 0, 8, 0, 0, 5};
    ahb(IDX_CFG1, 1'b1, 8'h0c);
    ahb(IDX_PHASE, 1'b1, 8'h10);
    for (int i = 0; i < 9; i++) begin
      ahb(IDX_STATUS, 1'b1, rt[i]);
      ahb(IDX_CFG2, 1'b1, c2[i]);
      if (i < 8) repeat (300) @(posedge i_clk);
      if (ex[i] == 0) chk({strobe, strobe_oe_n}, 2'b10);
      window(1024);
      chk(pulses, ex[i]);
    end
  endtask

  // ready flags: a read sets both, events clear one or both
  task automatic t_flags;
    for (int i = 0; i < 2; i++) begin
      ahb(IDX_STATUS, 1'b1, i ? 8'h90 : 8'h94);
      wait_pulse;
      ahb(IDX_STATUS, 1'b0, 8'h00);
      @(negedge i_clk);
      chk(flags, 2'b11);
      repeat (300) begin
        if (flags !== 2'b11) break;
        @(negedge i_clk);
      end
      chk({flags == 2'b11, ^flags}, i ? 2'b00 : 2'b01);
    end
    @(posedge i_clk);
  endtask

  // read snapshot frozen through the frame, independent and linked
  task automatic t_snap;
    ahb(IDX_CFG1, 1'b1, 8'h04);
    for (int i = 0; i < 2; i++) begin
      ahb(IDX_STATUS, 1'b1, i ? 8'h90 : 8'h9c);
      if (i) wait_pulse;
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      @(posedge i_clk);
      repeat (30) begin
        @(negedge i_clk);
        if (i) begin
          chk(w0, lk0);
          chk(w1, {8'h00, lk1[23:8]});
        end else begin
          chk(w0, s0);
          chk(w1, {8'h00, s1[23:8]});
        end
      end
      repeat (8) @(posedge i_clk);
    end
  endtask

  // reset for 20 cycles, then the scenarios in turn
  initial begin
    i_arst_n   = 1'b0;
    hsel       = 1'b0;
    htrans     = 2'b00;
    haddr      = 32'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    go         = 1'b0;
    cnt_en     = 1'b0;
    errors     = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    t_reset;
    t_fields;
    t_strobe;
    t_flags;
    t_snap;
    end_of_test;
  end
endmodule
